// ### pkg/lsms_pkg.sv
// constants, field layout and mode codes of the LED status mode select block
package lsms_pkg;
	// ==========================================
	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int STRETCH_BASE_MS = 50;
	localparam int TICK_MS = STRETCH_BASE_MS / 2;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int RESET_BLINK_MS = 1000;
	localparam logic [5:0] RESET_BLINK_TICKS = 6'(RESET_BLINK_MS / TICK_MS);
	localparam int PULSE_HZ = 5000;
	localparam int PULSE_CYCLES = CLK_HZ / PULSE_HZ;
	localparam int PULSE_DUTY_PCT = 20;
	localparam int SCLK_HALF = 8;
	localparam int STATUS_BITS = 12;

	// ==========================================
	// register map, word addresses
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_GLOBAL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_BEHAV = 4'h1;
	localparam logic [ADDR_W-1:0] REG_PORT_BASE = 4'h2;
	localparam logic [ADDR_W-1:0] REG_STAT_BASE = 4'h8;

	// ==========================================
	// fields
	localparam int DRIVE_BIT = 9;
	localparam int POL_LSB = 10;
	localparam int POL_W = 4;
	localparam int RATE_LSB = 0;
	localparam int PULSE_EN_BIT = 2;
	localparam int RST_BLINK_BIT = 3;
	localparam int MODE_LSB = 0;
	localparam int EXT_LSB = 16;
	localparam int STRETCH_LSB = 20;
	localparam int ACTSEL_BIT = 24;
	localparam logic [31:0] PORT_MASK = 32'h01ffffff;

	// ==========================================
	// reset values
	localparam logic [3:0] POL_RESET = 4'h0;
	localparam logic DRIVE_RESET = 1'b1;
	localparam logic [1:0] RATE_RESET = 2'h0;
	localparam logic PULSE_EN_RESET = 1'b0;
	localparam logic RST_BLINK_RESET = 1'b1;
	localparam logic [31:0] PORT_RESET = 32'h00000000;

	typedef enum logic [1:0] {SPD_10 = 2'h0, SPD_100 = 2'h1, SPD_1000 = 2'h2} lsms_speed_t;

	typedef enum logic [4:0] {
		M_LINK_ACT = 5'h00, M_L1000 = 5'h01, M_L100 = 5'h02, M_L10 = 5'h03,
		M_L100_1000 = 5'h04, M_L10_1000 = 5'h05, M_L10_100 = 5'h06, M_LFIBER = 5'h07,
		M_DUPLEX = 5'h08, M_COLL = 5'h09, M_ACT = 5'h0a, M_FIBER_ACT = 5'h0b,
		M_ANEG = 5'h0c, M_SERIAL = 5'h0d, M_OFF = 5'h0e, M_ON = 5'h0f,
		M_X_L1000 = 5'h10, M_X_L100 = 5'h11, M_X_ACT1000 = 5'h12, M_X_ACT100 = 5'h13,
		M_X_OFF = 5'h14, M_X_ON = 5'h15, M_X_FASTFAIL = 5'h16
	} lsms_mode_t;
endpackage : lsms_pkg

// ### rtl/lsms_led_status.sv
// per-port LED status mode select with drive, blink, stretch and serial stream
`timescale 1ns/1ns
`default_nettype none

module lsms_led_status #(
	parameter int NPORTS = 2,
	parameter int LEDS = 4,
	parameter int TICK_CYCLES = lsms_pkg::TICK_CYCLES,
	parameter int PULSE_CYCLES = lsms_pkg::PULSE_CYCLES
) (
	input wire logic clock, // core clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic [lsms_pkg::ADDR_W-1:0] regAddr, // register word address
	input wire logic [31:0] regWdata, // register write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	output logic [31:0] regRdata, // read data, cycle after strobe
	input wire logic [NPORTS-1:0] linkUp, // valid link per port
	input wire logic [2*NPORTS-1:0] linkSpeed, // speed code per port
	input wire logic [NPORTS-1:0] fiberMedia, // link is on fiber media
	input wire logic [NPORTS-1:0] fullDuplex, // link is full duplex
	input wire logic [NPORTS-1:0] collision, // collision seen
	input wire logic [NPORTS-1:0] txActivity, // transmit activity
	input wire logic [NPORTS-1:0] rxActivity, // receive activity
	input wire logic [NPORTS-1:0] anegFault, // autonegotiation fault
	input wire logic [NPORTS-1:0] fastLinkFail, // fast link failure indication
	output logic [NPORTS*LEDS-1:0] lampOut, // pin output level
	output logic [NPORTS*LEDS-1:0] lampOeN // pin output enable, low drives
);
	localparam int NPIN = NPORTS * LEDS;
	localparam int AW = lsms_pkg::ADDR_W;
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int PW = $clog2(PULSE_CYCLES + 1);
	localparam int PULSE_ON = PULSE_CYCLES * lsms_pkg::PULSE_DUTY_PCT / 100;
	localparam int SBITS = lsms_pkg::STATUS_BITS * NPORTS;
	localparam int SBW = $clog2(SBITS);

	typedef enum logic [1:0] {SER_LOAD, SER_LOW, SER_HIGH} lsms_ser_t;

	// ==========================================
	// registers
	logic [3:0] polarity_r;
	logic driveSel_r;
	logic [1:0] rate_r;
	logic pulseEn_r;
	logic rstBlinkEn_r;
	logic [31:0] portCfg_r [NPORTS];
	logic [31:0] rdMux;
	logic [NPIN-1:0] pinLvl;
	logic [NPIN-1:0] pinAct;
	logic [NPIN-1:0] pinHold;
	logic [4:0] stretchCnt [NPIN];
	logic [NPIN-1:0] lampOutNxt;
	logic [NPIN-1:0] lampOeNxt;

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			polarity_r <= lsms_pkg::POL_RESET;
			driveSel_r <= lsms_pkg::DRIVE_RESET;
			rate_r <= lsms_pkg::RATE_RESET;
			pulseEn_r <= lsms_pkg::PULSE_EN_RESET;
			rstBlinkEn_r <= lsms_pkg::RST_BLINK_RESET;
			for (int p = 0; p < NPORTS; p++)
				portCfg_r[p] <= lsms_pkg::PORT_RESET;
		end
		else if (regWr)
		begin
			if (regAddr == lsms_pkg::REG_GLOBAL)
			begin
				polarity_r <= regWdata[lsms_pkg::POL_LSB +: lsms_pkg::POL_W];
				driveSel_r <= regWdata[lsms_pkg::DRIVE_BIT];
			end
			if (regAddr == lsms_pkg::REG_BEHAV)
			begin
				rate_r <= regWdata[lsms_pkg::RATE_LSB +: 2];
				pulseEn_r <= regWdata[lsms_pkg::PULSE_EN_BIT];
				rstBlinkEn_r <= regWdata[lsms_pkg::RST_BLINK_BIT];
			end
			for (int p = 0; p < NPORTS; p++)
				if (regAddr == lsms_pkg::REG_PORT_BASE + AW'(p))
					portCfg_r[p] <= regWdata & lsms_pkg::PORT_MASK;
		end
	end

	// unmapped addresses read as zero
	always_comb
	begin
		rdMux = 32'h00000000;
		if (regAddr == lsms_pkg::REG_GLOBAL)
		begin
			rdMux[lsms_pkg::POL_LSB +: lsms_pkg::POL_W] = polarity_r;
			rdMux[lsms_pkg::DRIVE_BIT] = driveSel_r;
		end
		if (regAddr == lsms_pkg::REG_BEHAV)
		begin
			rdMux[lsms_pkg::RATE_LSB +: 2] = rate_r;
			rdMux[lsms_pkg::PULSE_EN_BIT] = pulseEn_r;
			rdMux[lsms_pkg::RST_BLINK_BIT] = rstBlinkEn_r;
		end
		for (int p = 0; p < NPORTS; p++)
		begin
			if (regAddr == lsms_pkg::REG_PORT_BASE + AW'(p))
				rdMux = portCfg_r[p];
			if (regAddr == lsms_pkg::REG_STAT_BASE + AW'(p))
			begin
				rdMux[LEDS-1:0] = pinLvl[p*LEDS +: LEDS];
				rdMux[LEDS] = linkUp[p];
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
			regRdata <= 32'h00000000;
		else
			regRdata <= regRd ? rdMux : 32'h00000000;
	end

	// ==========================================
	// time base: 25 ms tick drives every blink and stretch rate
	logic [TW-1:0] tickCnt;
	logic tick;
	logic [3:0] blinkCnt;
	logic phase;
	logic [5:0] rstWinCnt;
	logic rstWin;
	logic [PW-1:0] pulseCnt;
	logic pulseOn;

	assign tick = (tickCnt == TW'(TICK_CYCLES - 1));
	// rate 0 is the slowest blink; each step doubles the frequency
	assign phase = blinkCnt[2'd3 - rate_r];
	assign rstWin = rstBlinkEn_r && (rstWinCnt != lsms_pkg::RESET_BLINK_TICKS);
	assign pulseOn = (pulseCnt < PW'(PULSE_ON));

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			tickCnt <= '0;
			blinkCnt <= 4'h0;
		end
		else
		begin
			tickCnt <= tick ? '0 : tickCnt + TW'(1);
			if (tick)
				blinkCnt <= blinkCnt + 4'h1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
			rstWinCnt <= 6'h00;
		else if (tick && rstWinCnt != lsms_pkg::RESET_BLINK_TICKS)
			rstWinCnt <= rstWinCnt + 6'h01;
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
			pulseCnt <= '0;
		else
			pulseCnt <= (pulseCnt == PW'(PULSE_CYCLES - 1)) ? '0 : pulseCnt + PW'(1);
	end

	// ==========================================
	// serial stream on port 0
	logic serialOn;
	lsms_ser_t serState;
	logic [SBITS-1:0] serShift;
	logic [SBW-1:0] serBit;
	logic [3:0] serDiv;
	logic [SBITS-1:0] statusAll;
	logic serialLedDout;
	logic serialLedSclk;

	assign serialOn = (portCfg_r[0][3:0] == 4'hd) && !portCfg_r[0][lsms_pkg::EXT_LSB];
	assign serialLedDout = serShift[0];
	assign serialLedSclk = (serState == SER_HIGH);

	for (genvar p = 0; p < NPORTS; p++)
	begin : g_stat
		logic [1:0] sp;
		logic fact;
		assign sp = linkSpeed[2*p +: 2];
		assign fact = fiberMedia[p] && (txActivity[p] || rxActivity[p]);
		assign statusAll[p*lsms_pkg::STATUS_BITS +: lsms_pkg::STATUS_BITS] = {
			anegFault[p], rxActivity[p], txActivity[p], fact,
			txActivity[p] || rxActivity[p], collision[p],
			linkUp[p] && fullDuplex[p], linkUp[p] && fiberMedia[p],
			linkUp[p] && sp == lsms_pkg::SPD_10, linkUp[p] && sp == lsms_pkg::SPD_100,
			linkUp[p] && sp == lsms_pkg::SPD_1000, linkUp[p]};
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			serState <= SER_LOAD;
			serShift <= '0;
			serBit <= '0;
			serDiv <= 4'h0;
		end
		else
		begin
			case (serState)
				SER_LOAD:
				begin
					serShift <= statusAll;
					serBit <= '0;
					serDiv <= 4'h0;
					if (serialOn)
						serState <= SER_LOW;
				end
				SER_LOW:
				begin
					serDiv <= serDiv + 4'h1;
					if (serDiv == 4'(lsms_pkg::SCLK_HALF - 1))
					begin
						serDiv <= 4'h0;
						serState <= SER_HIGH;
					end
				end
				SER_HIGH:
				begin
					serDiv <= serDiv + 4'h1;
					if (serDiv == 4'(lsms_pkg::SCLK_HALF - 1))
					begin
						serDiv <= 4'h0;
						serShift <= serShift >> 1;
						serBit <= serBit + SBW'(1);
						serState <= (serBit == SBW'(SBITS - 1) || !serialOn) ? SER_LOAD : SER_LOW;
					end
				end
				default:
					serState <= SER_LOAD;
			endcase
		end
	end

	// ==========================================
	// per-pin mode decode and drive
	for (genvar k = 0; k < NPIN; k++)
	begin : g_pin
		localparam int P = k / LEDS;
		localparam int I = k % LEDS;
		logic [4:0] effMode;
		logic base;
		logic act;
		logic forced;
		logic noPulse;
		logic isSerial;
		logic blinkSel;
		logic lvl;
		logic lk;
		logic fib;
		logic s10;
		logic s100;
		logic s1000;
		logic anyAct;
		logic actSel;

		assign lk = linkUp[P];
		assign fib = fiberMedia[P];
		assign s10 = lk && linkSpeed[2*P +: 2] == lsms_pkg::SPD_10;
		assign s100 = lk && linkSpeed[2*P +: 2] == lsms_pkg::SPD_100;
		assign s1000 = lk && linkSpeed[2*P +: 2] == lsms_pkg::SPD_1000;
		assign anyAct = txActivity[P] || rxActivity[P];
		assign actSel = portCfg_r[P][lsms_pkg::ACTSEL_BIT];
		assign blinkSel = !portCfg_r[P][lsms_pkg::STRETCH_LSB + I];
		assign effMode = {portCfg_r[P][lsms_pkg::EXT_LSB + I], portCfg_r[P][4*I +: 4]};

		always_comb
		begin
			base = 1'b0;
			act = 1'b0;
			forced = 1'b0;
			noPulse = 1'b0;
			isSerial = 1'b0;
			case (effMode)
				lsms_pkg::M_LINK_ACT: begin base = lk; act = lk && anyAct; end
				lsms_pkg::M_L1000: begin base = s1000; act = s1000 && anyAct; end
				lsms_pkg::M_L100: begin base = s100; act = s100 && anyAct; end
				lsms_pkg::M_L10: begin base = s10 && !fib; act = base && anyAct; end
				lsms_pkg::M_L100_1000: begin base = s100 || s1000; act = base && anyAct; end
				lsms_pkg::M_L10_1000:
				begin
					base = (s10 && !fib) || s1000;
					act = base && anyAct;
				end
				lsms_pkg::M_L10_100: begin base = (s10 && !fib) || s100; act = base && anyAct; end
				lsms_pkg::M_LFIBER: begin base = fib && (s100 || s1000); act = base && anyAct; end
				lsms_pkg::M_DUPLEX:
				begin
					base = lk && fullDuplex[P];
					act = lk && !fullDuplex[P] && collision[P];
				end
				lsms_pkg::M_COLL: act = collision[P];
				lsms_pkg::M_ACT: act = actSel ? txActivity[P] : anyAct;
				lsms_pkg::M_FIBER_ACT:
					act = fib && (s100 || s1000) && (actSel ? rxActivity[P] : anyAct);
				lsms_pkg::M_ANEG: begin base = anegFault[P]; forced = 1'b1; end
				lsms_pkg::M_SERIAL: isSerial = (k == 0);
				lsms_pkg::M_OFF: forced = 1'b1;
				lsms_pkg::M_ON: begin base = 1'b1; forced = 1'b1; end
				lsms_pkg::M_X_L1000: base = fib && s1000;
				lsms_pkg::M_X_L100: base = fib && s100;
				lsms_pkg::M_X_ACT1000: act = fib && s1000 && anyAct;
				lsms_pkg::M_X_ACT100: act = fib && s100 && anyAct;
				lsms_pkg::M_X_OFF: forced = 1'b1;
				lsms_pkg::M_X_ON: begin base = 1'b1; forced = 1'b1; noPulse = 1'b1; end
				lsms_pkg::M_X_FASTFAIL: begin base = fastLinkFail[P]; forced = 1'b1; end
				default: base = 1'b0;
			endcase
		end

		// stretch restarts on every activity cycle; +1 covers the partial first tick
		always_ff @(posedge clock)
		begin
			if (!rstn)
				stretchCnt[k] <= 5'h00;
			else if (act && !blinkSel)
				stretchCnt[k] <= (5'h02 << rate_r) + 5'h01;
			else if (tick && stretchCnt[k] != 5'h00)
				stretchCnt[k] <= stretchCnt[k] - 5'h01;
		end

		assign pinAct[k] = act;
		assign pinHold[k] = blinkSel ? act : (stretchCnt[k] != 5'h00);

		always_comb
		begin
			lvl = pinHold[k] ? (blinkSel ? phase : !base) : base;
			if (forced)
				lvl = base;
			else if (rstWin && !isSerial && effMode != lsms_pkg::M_X_OFF)
				lvl = phase;
			// power-saving pulsing trades brightness for current
			if (pulseEn_r && !noPulse)
				lvl = lvl && pulseOn;
		end

		assign pinLvl[k] = lvl && !isSerial;

		always_comb
		begin
			if (k == 0 && serialOn)
			begin
				lampOutNxt[k] = serialLedDout;
				lampOeNxt[k] = 1'b0;
			end
			else if (k == 1 && serialOn)
			begin
				lampOutNxt[k] = serialLedSclk;
				lampOeNxt[k] = 1'b0;
			end
			else
			begin
				lampOutNxt[k] = lvl ? polarity_r[I] : !polarity_r[I];
				lampOeNxt[k] = !lvl && driveSel_r;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			lampOut <= {NPIN{1'b1}};
			lampOeN <= {NPIN{1'b1}};
		end
		else
		begin
			lampOut <= lampOutNxt;
			lampOeN <= lampOeNxt;
		end
	end

	// ==========================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence sStretchBurst;
		pinAct[0] && portCfg_r[0][lsms_pkg::STRETCH_LSB] ##1 !pinAct[0];
	endsequence

	a_reset_polarity: assert property ($rose(rstn) |-> polarity_r == 4'h0 && driveSel_r)
		else $error("polarity or drive select not at reset value");
	a_active_grounds: assert property (pinLvl[0] |=> !lampOeN[0])
		else $error("asserted LED not driven");
	a_idle_tristate: assert property (!pinLvl[0] && driveSel_r && !serialOn |=> lampOeN[0])
		else $error("inactive LED not tristated");
	a_forced_off: assert property (g_pin[0].effMode == 5'h0e |=>
		lampOut[0] == !$past(polarity_r[0]))
		else $error("forced off LED is asserted");
	a_forced_on_nopulse: assert property (g_pin[0].effMode == 5'h15 |=>
		lampOut[0] == $past(polarity_r[0]) && !lampOeN[0])
		else $error("forced on LED not asserted steadily");
	a_undefined_off: assert property (g_pin[0].effMode > 5'h16 && !rstWin |-> !pinLvl[0])
		else $error("undefined mode asserted LED");
	a_aneg_fault: assert property (g_pin[0].effMode == 5'h0c && !pulseEn_r |->
		pinLvl[0] == anegFault[0])
		else $error("fault mode does not follow fault");
	a_fast_fail: assert property (g_pin[0].effMode == 5'h16 && !pulseEn_r |->
		pinLvl[0] == fastLinkFail[0])
		else $error("fast fail mode does not follow indication");
	a_link_gig: assert property (g_pin[0].effMode == 5'h01 && !rstWin && !pulseEn_r
		&& !pinHold[0] |-> pinLvl[0] == (linkUp[0] && linkSpeed[1:0] == 2'h2))
		else $error("gigabit link mode wrong");
	a_blink_steady: assert property (tick |=> blinkCnt == $past(blinkCnt) + 4'h1)
		else $error("blink counter missed a tick");
	a_blink_hold: assert property (!tick |=> $stable(blinkCnt))
		else $error("blink counter moved without a tick");
	a_stretch_len: assert property (pinAct[0] && portCfg_r[0][lsms_pkg::STRETCH_LSB] |=>
		stretchCnt[0] == (5'h02 << $past(rate_r)) + 5'h01)
		else $error("stretch length wrong");
	a_stretch_hold: assert property (sStretchBurst |-> pinHold[0])
		else $error("stretch ended at once");
	a_serial_pin: assert property (serialOn |=> !lampOeN[0] && lampOut[0] == $past(serialLedDout))
		else $error("serial data not on pin");
endmodule : lsms_led_status

`default_nettype wire

// ### testbench/lsms_lamp_model.sv
// behavioural model of the lamps hanging on the LED pins
`timescale 1ns/1ns
`default_nettype none

module lsms_lamp_model #(
	parameter int N = 8
) (
	input wire logic [N-1:0] lampOut, // pin level from the block
	input wire logic [N-1:0] lampOeN, // pin enable from the block, low drives
	input wire logic [3:0] polarity, // programmed polarity per LED index
	output logic [N-1:0] pinLevel, // resolved pin level
	output logic [N-1:0] lit // lamp shows the asserted state
);
	// ==========================================
	// pin resolution
	always_comb
	begin
		for (int k = 0; k < N; k++)
		begin
			// a tristated pin floats up to the rail through the lamp
			pinLevel[k] = lampOeN[k] ? 1'b1 : lampOut[k];
			lit[k] = !lampOeN[k] && (lampOut[k] === polarity[k % 4]);
		end
	end
endmodule : lsms_lamp_model

`default_nettype wire

// ### testbench/lsms_led_status_tb_top.sv
// self-checking testbench of the LED status mode select block
`timescale 1ns/1ns
`default_nettype none

module lsms_led_status_tb_top;
	localparam int TICK = 4;
	localparam logic [6:0] COND [6] = '{7'h70, 7'h66, 7'h6f, 7'h51, 7'h5e, 7'h40};
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWdata = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdata;
	logic [1:0] linkUp = 2'h0, fiberMedia = 2'h0, fullDuplex = 2'h0, collision = 2'h0;
	logic [1:0] txActivity = 2'h0, rxActivity = 2'h0, anegFault = 2'h0, fastLinkFail = 2'h0;
	logic [3:0] linkSpeed = 4'hf;
	logic [7:0] lampOut, lampOeN, pinLevel, lit;
	logic [3:0] pol = 4'h0;
	logic drv = 1'b1;
	logic [31:0] rdv;
	int mismatches = 0;
	int n_compared = 0;
	int ones, edges;

	always #10 clock = ~clock;

	lsms_led_status #(.NPORTS(2), .LEDS(4), .TICK_CYCLES(TICK), .PULSE_CYCLES(10)) i_dut (
		.clock(clock), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .linkUp(linkUp), .linkSpeed(linkSpeed),
		.fiberMedia(fiberMedia), .fullDuplex(fullDuplex), .collision(collision),
		.txActivity(txActivity), .rxActivity(rxActivity), .anegFault(anegFault),
		.fastLinkFail(fastLinkFail), .lampOut(lampOut), .lampOeN(lampOeN));

	lsms_lamp_model #(.N(8)) i_lamps (.lampOut(lampOut), .lampOeN(lampOeN), .polarity(pol),
		.pinLevel(pinLevel), .lit(lit));

	// ==========================================
	// checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	// ==========================================
	// register access
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clock);
		regWr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask : rd

	task automatic glob(input logic [3:0] p, input logic d);
		wr(lsms_pkg::REG_GLOBAL, (32'(p) << lsms_pkg::POL_LSB) | (32'(d) << lsms_pkg::DRIVE_BIT));
		pol = p;
		drv = d;
	endtask : glob

	function automatic logic [31:0] cfg(input logic [4:0] m, input logic [3:0] st, input logic as);
		return {7'h0, as, st, {4{m[4]}}, {4{m[3:0]}}};
	endfunction : cfg

	// expected static state with no activity or collision
	function automatic logic exp_on(input logic [4:0] m, input logic [6:0] c);
		logic l, f, g, h, t;
		l = c[6];
		f = c[3];
		g = c[5:4] == 2'h2;
		h = c[5:4] == 2'h1;
		t = c[5:4] == 2'h0;
		case (m)
			5'd0: return l;
			5'd1: return l & g;
			5'd2: return l & h;
			5'd3: return l & t & !f;
			5'd4: return l & (h | g);
			5'd5: return l & ((t & !f) | g);
			5'd6: return l & (((t | h) & !f) | (h & f));
			5'd7: return l & f & (h | g);
			5'd8: return l & c[2];
			5'd12: return c[1];
			5'd15, 5'd21: return 1'b1;
			5'd16: return l & f & g;
			5'd17: return l & f & h;
			5'd22: return c[0];
			default: return 1'b0;
		endcase
	endfunction : exp_on

	task automatic setc(input logic [6:0] c, input logic [2:0] act);
		@(posedge clock);
		linkUp <= {2{c[6]}};
		linkSpeed <= {2{c[5:4]}};
		fiberMedia <= {2{c[3]}};
		fullDuplex <= {2{c[2]}};
		anegFault <= {2{c[1]}};
		fastLinkFail <= {2{c[0]}};
		txActivity <= {2{act[2]}};
		rxActivity <= {2{act[1]}};
		collision <= {2{act[0]}};
	endtask : setc

	// the resolved pin level proves the pull-up side of a released pin as well
	task automatic chk_port(input int p, input logic [3:0] on);
		for (int i = 0; i < 4; i++)
			check({lampOut[p*4+i], lampOeN[p*4+i], pinLevel[p*4+i]},
				on[i] ? {pol[i], 1'b0, pol[i]} : {~pol[i], drv, drv | ~pol[i]}, "lamp");
	endtask : chk_port

	task automatic meas(input int k, input int n);
		logic prev;
		@(posedge clock);
		#1 prev = lit[k];
		ones = 0;
		edges = 0;
		for (int i = 0; i < n; i++)
		begin
			ones += int'(prev);
			@(posedge clock);
			#1 if (lit[k] !== prev) edges++;
			prev = lit[k];
		end
	endtask : meas

	// blink half period is 8, 4, 2 or 1 ticks for rate 0..3
	task automatic blink_case(input logic [4:0] m, input logic [6:0] c, input logic as,
		input logic [2:0] act, input logic [1:0] rate, input logic blinks);
		setc(c, act);
		wr(lsms_pkg::REG_BEHAV, 32'(rate));
		wr(lsms_pkg::REG_PORT_BASE + 4'h1, cfg(m, 4'h0, as));
		repeat (3) @(posedge clock);
		meas(4, 128);
		check(32'(ones), blinks ? 32'd64 : 32'd0, "blink on time");
		check(32'(edges), blinks ? 32'(4 << rate) : 32'd0, "blink edges");
	endtask : blink_case

	initial
	begin
		repeat (90000) @(posedge clock);
		check(32'h1, 32'h0, "run length");
		finish_test();
	end

	initial
	begin
		repeat (2) @(posedge clock);
		#1 check({lampOut, lampOeN}, 32'h0000ffff, "lamps in reset");
		@(posedge clock);
		rstn <= 1'b1;
		rd(lsms_pkg::REG_GLOBAL, rdv);
		check(rdv, 32'h00000200, "global reset");
		rd(lsms_pkg::REG_BEHAV, rdv);
		check(rdv, 32'h00000008, "behaviour reset");
		rd(lsms_pkg::REG_PORT_BASE, rdv);
		check(rdv, 32'h00000000, "port reset");
		wr(lsms_pkg::REG_PORT_BASE + 4'h1, cfg(5'd14, 4'h0, 1'b0));
		repeat (3) @(posedge clock);
		meas(4, 64);
		check(32'(ones), 32'd0, "forced off in reset blink");
		wr(lsms_pkg::REG_BEHAV, 32'h0);
		repeat (200) @(posedge clock);
		wr(lsms_pkg::REG_PORT_BASE, 32'hffffffff);
		rd(lsms_pkg::REG_PORT_BASE, rdv);
		check(rdv, 32'h01ffffff, "port field width");
		wr(4'h5, 32'hffffffff);
		rd(4'h5, rdv);
		check(rdv, 32'h0, "unmapped read");
		wr(lsms_pkg::REG_PORT_BASE, 32'h0);
		// every mode against the six link-up conditions in COND, polarity and drive alternating
		for (int c = 0; c < 6; c++)
		begin
			setc(COND[c], 3'h0);
			glob(c % 2 ? 4'ha : 4'h0, c % 2 ? 1'b0 : 1'b1);
			for (int m = 0; m < 32; m++)
			begin
				wr(lsms_pkg::REG_PORT_BASE + 4'h1, cfg(5'(m), 4'h0, 1'b0));
				// port 0 as well, so the pin 0 assertions meet every mode
				wr(lsms_pkg::REG_PORT_BASE, cfg(5'(m), 4'h0, 1'b0));
				repeat (3) @(posedge clock);
				#1 chk_port(1, {4{exp_on(5'(m), COND[c])}});
				if (m != 13)
					chk_port(0, {4{exp_on(5'(m), COND[c])}});
			end
		end
		wr(lsms_pkg::REG_PORT_BASE + 4'h1, 32'h0000efef);
		repeat (3) @(posedge clock);
		#1 chk_port(1, 4'b0101);
		wr(lsms_pkg::REG_STAT_BASE + 4'h1, 32'h0);
		rd(lsms_pkg::REG_STAT_BASE + 4'h1, rdv);
		check(rdv, 32'h00000015, "port status");
		glob(4'h0, 1'b1);
		wr(lsms_pkg::REG_PORT_BASE, 32'h0000ef0d);
		repeat (3) @(posedge clock);
		#1 check({lampOut[3:2], lampOeN[3:0]}, 6'b10_1000, "serial side pins");
		meas(1, 64);
		check(32'(edges != 0), 32'h1, "serial clock runs");
		wr(lsms_pkg::REG_PORT_BASE, 32'h0);
		for (int r = 0; r < 4; r++)
			blink_case(5'd0, 7'h66, 1'b0, 3'h4, 2'(r), 1'b1);
		blink_case(5'd8, 7'h51, 1'b0, 3'h1, 2'h0, 1'b1);
		blink_case(5'd9, 7'h70, 1'b0, 3'h1, 2'h0, 1'b1);
		blink_case(5'd10, 7'h40, 1'b1, 3'h2, 2'h0, 1'b0);
		blink_case(5'd10, 7'h40, 1'b1, 3'h4, 2'h0, 1'b1);
		blink_case(5'd11, 7'h6f, 1'b0, 3'h4, 2'h0, 1'b1);
		blink_case(5'd11, 7'h6f, 1'b1, 3'h4, 2'h0, 1'b0);
		blink_case(5'd18, 7'h6f, 1'b0, 3'h4, 2'h0, 1'b1);
		blink_case(5'd19, 7'h6f, 1'b0, 3'h4, 2'h0, 1'b0);
		// one short activity pulse must hold the lamp for the stretch time
		setc(7'h40, 3'h0);
		wr(lsms_pkg::REG_PORT_BASE + 4'h1, cfg(5'd10, 4'hf, 1'b0));
		wr(lsms_pkg::REG_PORT_BASE, cfg(5'd10, 4'hf, 1'b0));
		for (int r = 0; r < 4; r++)
		begin
			wr(lsms_pkg::REG_BEHAV, 32'(r));
			setc(7'h40, 3'h4);
			setc(7'h40, 3'h0);
			meas(4, 200);
			check(32'(ones >= (8 << r) && ones <= (8 << r) + 6), 32'h1, "stretch time");
		end
		// pulsing dims every asserted pin except forced on in mode 21
		wr(lsms_pkg::REG_BEHAV, 32'(1 << lsms_pkg::PULSE_EN_BIT));
		wr(lsms_pkg::REG_PORT_BASE, cfg(5'd21, 4'h0, 1'b0));
		wr(lsms_pkg::REG_PORT_BASE + 4'h1, cfg(5'd15, 4'h0, 1'b0));
		repeat (3) @(posedge clock);
		meas(4, 100);
		check(32'(ones), 32'd20, "pulse duty");
		meas(0, 100);
		check(32'(ones), 32'd100, "forced on unpulsed");
		// leave non-reset settings so the mid-run reset has something to undo
		glob(4'h5, 1'b0);
		@(posedge clock);
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		#1 check({lampOut, lampOeN}, 32'h0000ffff, "lamps after reset");
		rd(lsms_pkg::REG_GLOBAL, rdv);
		check(rdv, 32'h00000200, "global after reset");
		finish_test();
	end
endmodule : lsms_led_status_tb_top

`default_nettype wire
